// ==== verilog/timer_irq_levels_pkg.sv ====
// Package with the register map, field layouts and carrier types of the timer interrupt level block.
`default_nettype none
package timer_irq_levels_pkg;

    // Bus widths and response codes.
    localparam int unsigned ADDR_W      = 8;
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned STRB_W      = DATA_W / 8;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFFS_SHORT_LEVELS = 8'h00;
    localparam logic [ADDR_W-1:0] OFFS_LONG_LEVELS  = 8'h04;
    localparam logic [ADDR_W-1:0] OFFS_LEVEL_ENABLE = 8'h08;
    localparam logic [ADDR_W-1:0] OFFS_ENABLE_FIVE  = 8'h0c;
    localparam logic [ADDR_W-1:0] OFFS_ENABLE_SIX   = 8'h10;
    localparam logic [ADDR_W-1:0] OFFS_WINNER       = 8'h14;

    // Source counts and field widths.
    localparam int unsigned LEVEL_W     = 2;
    localparam int unsigned SHORT_N     = 8;
    localparam int unsigned LONG_N      = 4;
    localparam int unsigned SRC_N       = SHORT_N + LONG_N;
    localparam int unsigned SRC_W       = 4;
    localparam int unsigned LEVEL_REG_W = 16;
    localparam int unsigned LONG_USED_W = LONG_N * LEVEL_W;

    // Reset values.
    localparam logic [LEVEL_REG_W-1:0] RESET_LEVELS       = 16'h0000;
    localparam logic                   RESET_LEVEL_ENABLE = 1'h0;
    localparam logic [SHORT_N-1:0]     RESET_ENABLE_FIVE  = 8'h00;
    localparam logic [LONG_N-1:0]      RESET_ENABLE_SIX   = 4'h0;

    // Encoded levels: 00 is level 1, 11 is level 4.
    localparam logic [LEVEL_W-1:0] LEVEL_ONE  = 2'h0;
    localparam logic [LEVEL_W-1:0] LEVEL_FOUR = 2'h3;

    // Region index of the register address, one word per register.
    typedef enum logic [2:0] {
        REG_SHORT_LEVELS = 3'b000,
        REG_LONG_LEVELS  = 3'b001,
        REG_LEVEL_ENABLE = 3'b010,
        REG_ENABLE_FIVE  = 3'b011,
        REG_ENABLE_SIX   = 3'b100,
        REG_WINNER       = 3'b101,
        REG_NONE         = 3'b111
    } reg_sel_type;

    // Result of priority resolution, also the readback layout of the winner register.
    typedef struct packed {
        logic               valid;
        logic [SRC_W-1:0]   source;
        logic [LEVEL_W-1:0] level;
    } winner_type;

    localparam int unsigned WINNER_W = $bits(winner_type);

endpackage
`default_nettype wire

// ==== verilog/timer_irq_priority_levels.sv ====
// Timer interrupt level registers with an AXI4-Lite slave and a level-based priority resolver.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Each source has a two-bit level field where 00 means level 1 up to 11 meaning level 4.
// - Among pending enabled sources the one with the higher level value wins.
// - Writes to either level register take effect only while level control is enabled.
// - The 8-bit timer level register holds timer n in bits 2n+1 to 2n for n from 0 to 7.
// - The 16-bit timer level register holds timer n in bits 2n+1 to 2n for n from 0 to 3.
// - Reset clears every level field to 0 so every source starts at level 1.
// - 8-bit timer levels pair with enable group five and 16-bit timer levels with group six.
module timer_irq_priority_levels
(
    input  wire logic                                       aclk,
    input  wire logic                                       aresetn,
    input  wire logic [timer_irq_levels_pkg::ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                                       s_axi_awvalid,
    output logic                                            s_axi_awready,
    input  wire logic [timer_irq_levels_pkg::DATA_W-1:0]    s_axi_wdata,
    input  wire logic [timer_irq_levels_pkg::STRB_W-1:0]    s_axi_wstrb,
    input  wire logic                                       s_axi_wvalid,
    output logic                                            s_axi_wready,
    output logic [1:0]                                      s_axi_bresp,
    output logic                                            s_axi_bvalid,
    input  wire logic                                       s_axi_bready,
    input  wire logic [timer_irq_levels_pkg::ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                                       s_axi_arvalid,
    output logic                                            s_axi_arready,
    output logic [timer_irq_levels_pkg::DATA_W-1:0]         s_axi_rdata,
    output logic [1:0]                                      s_axi_rresp,
    output logic                                            s_axi_rvalid,
    input  wire logic                                       s_axi_rready,
    input  wire logic [timer_irq_levels_pkg::SHORT_N-1:0]   short_timer_irq,
    input  wire logic [timer_irq_levels_pkg::LONG_N-1:0]    long_timer_irq,
    output logic [timer_irq_levels_pkg::LEVEL_REG_W-1:0]    short_levels,
    output logic [timer_irq_levels_pkg::LONG_USED_W-1:0]    long_levels,
    output timer_irq_levels_pkg::winner_type                winner
);

    ////////////////////////////////////////////////////////////////////////////////
    // Address decoding and byte-lane merging.

    // Maps a byte address onto the register it selects.
    function automatic timer_irq_levels_pkg::reg_sel_type decode_addr
    (
        input logic [timer_irq_levels_pkg::ADDR_W-1:0] addr
    );
        case (addr)
            timer_irq_levels_pkg::OFFS_SHORT_LEVELS: decode_addr = timer_irq_levels_pkg::REG_SHORT_LEVELS;
            timer_irq_levels_pkg::OFFS_LONG_LEVELS:  decode_addr = timer_irq_levels_pkg::REG_LONG_LEVELS;
            timer_irq_levels_pkg::OFFS_LEVEL_ENABLE: decode_addr = timer_irq_levels_pkg::REG_LEVEL_ENABLE;
            timer_irq_levels_pkg::OFFS_ENABLE_FIVE:  decode_addr = timer_irq_levels_pkg::REG_ENABLE_FIVE;
            timer_irq_levels_pkg::OFFS_ENABLE_SIX:   decode_addr = timer_irq_levels_pkg::REG_ENABLE_SIX;
            timer_irq_levels_pkg::OFFS_WINNER:       decode_addr = timer_irq_levels_pkg::REG_WINNER;
            default:                                 decode_addr = timer_irq_levels_pkg::REG_NONE;
        endcase
    endfunction

    // Replaces the bytes of a 16-bit register whose strobes are set.
    function automatic logic [15:0] merge_bytes
    (
        input logic [15:0] old_val,
        input logic [15:0] new_val,
        input logic [1:0]  strb
    );
        merge_bytes = {strb[1] ? new_val[15:8] : old_val[15:8],
                       strb[0] ? new_val[7:0]  : old_val[7:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Storage.

    logic [timer_irq_levels_pkg::ADDR_W-1:0]      aw_addr_r;
    logic                                         aw_held_r;
    logic [timer_irq_levels_pkg::DATA_W-1:0]      w_data_r;
    logic [timer_irq_levels_pkg::STRB_W-1:0]      w_strb_r;
    logic                                         w_held_r;
    logic [timer_irq_levels_pkg::LEVEL_REG_W-1:0] short_reg_r;
    logic [timer_irq_levels_pkg::LEVEL_REG_W-1:0] long_reg_r;
    logic                                         level_enable_r;
    logic [timer_irq_levels_pkg::SHORT_N-1:0]     enable_five_r;
    logic [timer_irq_levels_pkg::LONG_N-1:0]      enable_six_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Write channel control.

    // A write completes once both address and data are held and no response is outstanding.
    timer_irq_levels_pkg::reg_sel_type wr_sel;
    logic                              wr_fire;
    logic                              wr_mapped;
    logic                              level_wr_ok;
    logic [timer_irq_levels_pkg::LEVEL_REG_W-1:0] short_reg_nxt;
    logic [timer_irq_levels_pkg::LEVEL_REG_W-1:0] long_reg_nxt;
    assign wr_sel      = decode_addr(aw_addr_r);
    assign wr_fire     = aw_held_r && w_held_r && !s_axi_bvalid;
    assign wr_mapped   = (wr_sel != timer_irq_levels_pkg::REG_NONE);
    assign level_wr_ok = wr_fire && level_enable_r;

    // Byte strobes 0 and 1 choose which halves of a level register are replaced.
    assign short_reg_nxt = merge_bytes(short_reg_r, w_data_r[15:0], w_strb_r[1:0]);
    assign long_reg_nxt  = merge_bytes(long_reg_r, w_data_r[15:0], w_strb_r[1:0]);

    // Accepts address and data in either order and returns one response per write.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            aw_held_r     <= 1'b0;
            w_held_r      <= 1'b0;
            aw_addr_r     <= '0;
            w_data_r      <= '0;
            w_strb_r      <= '0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= timer_irq_levels_pkg::RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_addr_r     <= s_axi_awaddr;
                aw_held_r     <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data_r     <= s_axi_wdata;
                w_strb_r     <= s_axi_wstrb;
                w_held_r     <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_mapped ? timer_irq_levels_pkg::RESP_OKAY : timer_irq_levels_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register file.

    // Level registers reset to level 1 everywhere and change only while level control is on.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            short_reg_r    <= timer_irq_levels_pkg::RESET_LEVELS;
            long_reg_r     <= timer_irq_levels_pkg::RESET_LEVELS;
            level_enable_r <= timer_irq_levels_pkg::RESET_LEVEL_ENABLE;
            enable_five_r  <= timer_irq_levels_pkg::RESET_ENABLE_FIVE;
            enable_six_r   <= timer_irq_levels_pkg::RESET_ENABLE_SIX;
        end
        else
        begin
            if (level_wr_ok && wr_sel == timer_irq_levels_pkg::REG_SHORT_LEVELS)
            begin
                short_reg_r <= short_reg_nxt;
            end
            if (level_wr_ok && wr_sel == timer_irq_levels_pkg::REG_LONG_LEVELS)
            begin
                long_reg_r <= long_reg_nxt;
            end
            if (wr_fire && w_strb_r[0] && wr_sel == timer_irq_levels_pkg::REG_LEVEL_ENABLE)
            begin
                level_enable_r <= w_data_r[0];
            end
            if (wr_fire && w_strb_r[0] && wr_sel == timer_irq_levels_pkg::REG_ENABLE_FIVE)
            begin
                enable_five_r <= w_data_r[timer_irq_levels_pkg::SHORT_N-1:0];
            end
            if (wr_fire && w_strb_r[0] && wr_sel == timer_irq_levels_pkg::REG_ENABLE_SIX)
            begin
                enable_six_r <= w_data_r[timer_irq_levels_pkg::LONG_N-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read channel.

    // Each register widened to the bus word, so unused upper bits always read as zero.
    logic [timer_irq_levels_pkg::DATA_W-1:0] short_word;
    logic [timer_irq_levels_pkg::DATA_W-1:0] long_word;
    logic [timer_irq_levels_pkg::DATA_W-1:0] level_enable_word;
    logic [timer_irq_levels_pkg::DATA_W-1:0] enable_five_word;
    logic [timer_irq_levels_pkg::DATA_W-1:0] enable_six_word;
    logic [timer_irq_levels_pkg::DATA_W-1:0] winner_word;
    assign short_word        = {16'h0000, short_reg_r};
    assign long_word         = {16'h0000, long_reg_r};
    assign level_enable_word = {31'h00000000, level_enable_r};
    assign enable_five_word  = {24'h000000, enable_five_r};
    assign enable_six_word   = {28'h0000000, enable_six_r};
    assign winner_word       = {25'h0000000, winner};

    // Read data is chosen from the address as the request is taken.
    timer_irq_levels_pkg::reg_sel_type rd_sel;
    logic [timer_irq_levels_pkg::DATA_W-1:0] rd_word;
    assign rd_sel  = decode_addr(s_axi_araddr);
    assign rd_word =
        (rd_sel == timer_irq_levels_pkg::REG_SHORT_LEVELS) ? short_word :
        (rd_sel == timer_irq_levels_pkg::REG_LONG_LEVELS)  ? long_word :
        (rd_sel == timer_irq_levels_pkg::REG_LEVEL_ENABLE) ? level_enable_word :
        (rd_sel == timer_irq_levels_pkg::REG_ENABLE_FIVE)  ? enable_five_word :
        (rd_sel == timer_irq_levels_pkg::REG_ENABLE_SIX)   ? enable_six_word :
        (rd_sel == timer_irq_levels_pkg::REG_WINNER)       ? winner_word :
                                                             32'h00000000;

    // One read at a time; the data answer follows the address handshake by one cycle.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= timer_irq_levels_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= (rd_sel == timer_irq_levels_pkg::REG_NONE) ?
                             timer_irq_levels_pkg::RESP_SLVERR : timer_irq_levels_pkg::RESP_OKAY;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Priority resolution.

    // Flattened per-source levels and pending-and-enabled requests; short timers first.
    logic [timer_irq_levels_pkg::LEVEL_W-1:0] src_level [timer_irq_levels_pkg::SRC_N];
    logic [timer_irq_levels_pkg::SRC_N-1:0]   src_req;

    // Each timer takes two bits at 2n+1..2n of its register.
    genvar g;
    generate
        for (g = 0; g < timer_irq_levels_pkg::SHORT_N; g++)
        begin : g_short
            assign src_level[g] = short_reg_r[2*g +: timer_irq_levels_pkg::LEVEL_W];
            assign src_req[g]   = short_timer_irq[g] && enable_five_r[g];
        end
        for (g = 0; g < timer_irq_levels_pkg::LONG_N; g++)
        begin : g_long
            assign src_level[timer_irq_levels_pkg::SHORT_N+g] =
                long_reg_r[2*g +: timer_irq_levels_pkg::LEVEL_W];
            assign src_req[timer_irq_levels_pkg::SHORT_N+g] = long_timer_irq[g] && enable_six_r[g];
        end
    endgenerate

    // Highest level wins; on a tie the lower source number keeps the win.
    timer_irq_levels_pkg::winner_type winner_nxt;
    always_comb
    begin
        winner_nxt = '0;
        for (int i = 0; i < timer_irq_levels_pkg::SRC_N; i++)
        begin
            if (src_req[i] && (!winner_nxt.valid || src_level[i] > winner_nxt.level))
            begin
                winner_nxt.valid  = 1'b1;
                winner_nxt.source = i[timer_irq_levels_pkg::SRC_W-1:0];
                winner_nxt.level  = src_level[i];
            end
        end
    end

    // Registered outputs toward the interrupt acceptance logic.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            winner       <= '0;
            short_levels <= timer_irq_levels_pkg::RESET_LEVELS;
            long_levels  <= '0;
        end
        else
        begin
            winner       <= winner_nxt;
            short_levels <= short_reg_r;
            long_levels  <= long_reg_r[timer_irq_levels_pkg::LONG_USED_W-1:0];
        end
    end

endmodule
`default_nettype wire

// ==== testbench/timer_irq_levels_props.sv ====
// Checker with the port-level properties of the timer interrupt level block.
`timescale 1ns/10ps
`default_nettype none
module timer_irq_levels_props
(
    input wire logic                             aclk,
    input wire logic                             aresetn,
    input wire logic                             s_axi_awvalid,
    input wire logic                             s_axi_awready,
    input wire logic                             s_axi_wvalid,
    input wire logic                             s_axi_wready,
    input wire logic                             s_axi_bvalid,
    input wire logic                             s_axi_arvalid,
    input wire logic                             s_axi_arready,
    input wire logic                             s_axi_rvalid,
    input wire logic [3:0]                       long_timer_irq,
    input wire logic [7:0]                       short_timer_irq,
    input wire logic [15:0]                      short_levels,
    input wire logic [7:0]                       long_levels,
    input wire timer_irq_levels_pkg::winner_type winner
);
    ////////////////////////////////////////////////////////////////
    // Level fields of the source that the resolver reports.
    wire logic [1:0] short_sel = short_levels[{winner.source[2:0], 1'b0} +: 2];
    wire logic [1:0] long_sel  = long_levels[{winner.source[1:0], 1'b0} +: 2];

    // Requests as they stood one edge before the resolver's answer.
    logic [11:0] pend_prev;
    always_ff @(posedge aclk)
    begin
        pend_prev <= {long_timer_irq, short_timer_irq};
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Reset is checked while it is applied, so its own disable is off.
    AST_RESET_CLEARS: assert property (disable iff (1'b0) !aresetn |=> short_levels == 16'h0000
        && long_levels == 8'h00 && winner == 7'h00) else $error("levels not cleared by reset");
    AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write response late");
    AST_BUSY_REFUSES: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("new write taken during response");
    AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    AST_LEVELS_NEED_WRITE: assert property (!$stable(short_levels) || !$stable(long_levels)
        |-> $past(s_axi_bvalid)) else $error("levels changed without a write");
    AST_IDLE_NO_WINNER: assert property (short_timer_irq == 8'h00 && long_timer_irq == 4'h0
        |=> !winner.valid) else $error("winner without pending source");
    AST_SOURCE_PENDING: assert property (winner.valid |-> pend_prev[winner.source])
        else $error("winner source not pending");
    AST_SHORT_LEVEL: assert property (winner.valid && winner.source < 4'h8 |-> winner.level == short_sel)
        else $error("short timer winner level wrong");
    AST_LONG_LEVEL: assert property (winner.valid && winner.source >= 4'h8 |-> winner.level == long_sel)
        else $error("long timer winner level wrong");

    // Main scenarios reached.
    COV_WRITE: cover property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready);
    COV_LONG_WINS: cover property (winner.valid && winner.source >= 4'h8);
    COV_SHORT_WINS: cover property (winner.valid && winner.source < 4'h8);
endmodule
bind timer_irq_priority_levels timer_irq_levels_props props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .long_timer_irq, .short_timer_irq, .short_levels, .long_levels, .winner);
`default_nettype wire

// ==== testbench/irq_sources_model.sv ====
// Model of the timer interrupt sources and of the core that accepts the winning request.
`timescale 1ns/10ps
`default_nettype none
module irq_sources_model
(
    input  wire logic                             aclk,
    input  wire logic                             aresetn,
    input  wire logic [11:0]                      raise,
    input  wire logic                             accept,
    input  wire timer_irq_levels_pkg::winner_type winner,
    output logic [7:0]                            short_timer_irq,
    output logic [3:0]                            long_timer_irq
);
    logic [11:0] pend_r;
    logic [11:0] pend_nxt;
    logic [11:0] taken;

    ////////////////////////////////////////////////////////////////
    // The core acknowledges only the source that the resolver reports.
    assign taken    = (accept && winner.valid) ? (12'h001 << winner.source) : 12'h000;
    assign pend_nxt = (pend_r | raise) & ~taken;

    // Pending requests stay up until acknowledged.
    always_ff @(posedge aclk)
    begin
        pend_r <= aresetn ? pend_nxt : 12'h000;
    end

    assign short_timer_irq = pend_r[7:0];
    assign long_timer_irq  = pend_r[11:8];
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the timer interrupt level block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("mismatch %s expected %h seen %h", what, exp, got); \
        end \
    end
module tb;
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] data;
        logic [3:0]  strb;
        logic [1:0]  bresp;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } row_type;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic        s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic [11:0] raise = 12'h000;
    logic        accept = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata;
    logic [7:0]  short_timer_irq, long_levels;
    logic [3:0]  long_timer_irq;
    logic [15:0] short_levels;
    timer_irq_levels_pkg::winner_type winner;
    int          num_errors = 0;
    int          check_count = 0;
    // Register writes with read-back; levels go in before any source is enabled.
    row_type rows [9] = '{
        '{8'h08, 32'h0000_0001, 4'hf, 2'h0, 32'h0000_0001, 2'h0},
        '{8'h00, 32'h0000_1b27, 4'hf, 2'h0, 32'h0000_1b27, 2'h0},
        '{8'h04, 32'hffff_ffc6, 4'hf, 2'h0, 32'h0000_ffc6, 2'h0},
        '{8'h00, 32'hffff_a5ff, 4'h1, 2'h0, 32'h0000_1bff, 2'h0},
        '{8'h04, 32'h0000_3900, 4'h2, 2'h0, 32'h0000_39c6, 2'h0},
        '{8'h18, 32'h0000_0003, 4'hf, 2'h2, 32'h0000_0000, 2'h2},
        '{8'h14, 32'h0000_007f, 4'hf, 2'h0, 32'h0000_0000, 2'h0},
        '{8'h0c, 32'h0000_00ff, 4'hf, 2'h0, 32'h0000_00ff, 2'h0},
        '{8'h10, 32'h0000_000f, 4'hf, 2'h0, 32'h0000_000f, 2'h0}};

    timer_irq_priority_levels dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .short_timer_irq, .long_timer_irq, .short_levels,
        .long_levels, .winner);
    irq_sources_model partner (.aclk, .aresetn, .raise, .accept, .winner, .short_timer_irq,
        .long_timer_irq);

    ////////////////////////////////////////////////////////////////
    // Free-running clock and a watchdog against hangs.
    initial
    begin
        forever #5 aclk = ~aclk;
    end
    initial
    begin
        repeat (5000) @(posedge aclk);
        num_errors++;
        final_report();
    end

    // Write master: offers address and data together, releases each once taken.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] r);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    // Read master with comparison of data and response.
    task automatic expect_read(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        `CHK("rdata", d, s_axi_rdata)
        `CHK("rresp", r, s_axi_rresp)
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    // Raises requests or accepts the winner, then looks at the resolved winner.
    task automatic irq_step(input logic [11:0] r, input logic a, input logic [6:0] e);
        raise  <= r;
        accept <= a;
        @(posedge aclk);
        raise  <= 12'h000;
        accept <= 1'b0;
        repeat (3) @(posedge aclk);
        `CHK("winner", e, winner)
    endtask

    task automatic final_report();
        if (num_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // Main sequence.
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        expect_read(8'h00, 32'h0000_0000, 2'h0);
        expect_read(8'h04, 32'h0000_0000, 2'h0);
        foreach (rows[i])
        begin
            axi_write(rows[i].addr, rows[i].data, rows[i].strb, resp);
            `CHK("bresp", rows[i].bresp, resp)
            expect_read(rows[i].addr, rows[i].rdata, rows[i].rresp);
        end
        `CHK("short_levels", 16'h1bff, short_levels)
        `CHK("long_levels", 8'hc6, long_levels)
        // Levels now: short 3,3,3,3,3,2,1,0 and long 2,1,0,3.
        irq_step(12'h880, 1'b0, 7'h6f);
        expect_read(8'h14, 32'h0000_006f, 2'h0);
        irq_step(12'h000, 1'b1, 7'h5c);
        irq_step(12'h240, 1'b0, 7'h59);
        irq_step(12'h000, 1'b1, 7'h65);
        irq_step(12'h000, 1'b1, 7'h5c);
        irq_step(12'h000, 1'b1, 7'h00);
        // With group six off the 16-bit timers drop out of resolution.
        axi_write(8'h10, 32'h0000_0000, 4'hf, resp);
        irq_step(12'h880, 1'b0, 7'h5c);
        irq_step(12'h000, 1'b1, 7'h00);
        // Level writes are dropped while level control is off.
        axi_write(8'h0c, 32'h0000_0000, 4'hf, resp);
        axi_write(8'h08, 32'h0000_0000, 4'hf, resp);
        axi_write(8'h00, 32'h0000_5555, 4'hf, resp);
        `CHK("bresp", 2'h0, resp)
        expect_read(8'h00, 32'h0000_1bff, 2'h0);
        axi_write(8'h04, 32'h0000_0000, 4'hf, resp);
        `CHK("bresp", 2'h0, resp)
        expect_read(8'h04, 32'h0000_39c6, 2'h0);
        `CHK("long_levels", 8'hc6, long_levels)
        // A second reset in mid-run.
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        `CHK("short_levels", 16'h0000, short_levels)
        expect_read(8'h04, 32'h0000_0000, 2'h0);
        expect_read(8'h08, 32'h0000_0000, 2'h0);
        final_report();
    end
endmodule
`default_nettype wire
